// ### design/crtv_cfg.svh
`ifndef CRTV_CFG_SVH
`define CRTV_CFG_SVH
`define CRTV_IDX_ULOC      8'h14
`define CRTV_IDX_VBS_LO    8'h15
`define CRTV_IDX_VBE       8'h16
`define CRTV_IDX_MODE      8'h17
`define CRTV_IDX_LCMP_LO   8'h18
`define CRTV_IDX_OVFL      8'h07
`define CRTV_IDX_MAXSCAN   8'h09
`define CRTV_ULOC_DW       6
`define CRTV_ULOC_CB4      5
`define CRTV_MODE_TEN      7
`define CRTV_MODE_WB       6
`define CRTV_MODE_AW       5
`define CRTV_MODE_CBT      3
`define CRTV_MODE_HRS      2
`define CRTV_MODE_SRS      1
`define CRTV_MODE_CMS      0
`define CRTV_OVFL_LC8      4
`define CRTV_OVFL_VBLANK_START_BIT8     3
`define CRTV_MSL_LC9       6
`define CRTV_MSL_VBLANK_START_BIT9      5
`define CRTV_RESET_VAL     8'h00
`endif

// ### design/crtv_pkg.sv
package crtv_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } crtv_req_t;
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic den;
    logic blank;
  } crtv_timing_t;
endpackage : crtv_pkg

// ### design/crtv_regfile.sv
`timescale 1ns/1ns
`include "crtv_cfg.svh"
// Indexed register storage with registered read data
module crtv_regfile (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Access
  input  wire crtv_pkg::crtv_req_t req,
  output logic [7:0]            rdata_q,
  // Register contents
  output logic [7:0]            uloc_q,
  output logic [7:0]            vbs_q,
  output logic [7:0]            vbe_q,
  output logic [7:0]            mode_q,
  output logic [7:0]            lcmp_q,
  output logic [7:0]            ovfl_q,
  output logic [7:0]            msl_q
);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uloc_q <= `CRTV_RESET_VAL;
      vbs_q  <= `CRTV_RESET_VAL;
      vbe_q  <= `CRTV_RESET_VAL;
      mode_q <= `CRTV_RESET_VAL;
      lcmp_q <= `CRTV_RESET_VAL;
      ovfl_q <= `CRTV_RESET_VAL;
      msl_q  <= `CRTV_RESET_VAL;
    end else if (req.wr) begin
      if (req.index == `CRTV_IDX_ULOC) begin
        uloc_q <= {1'b0, req.wdata[6:0]};
      end else if (req.index == `CRTV_IDX_VBS_LO) begin
        vbs_q <= req.wdata;
      end else if (req.index == `CRTV_IDX_VBE) begin
        vbe_q <= {1'b0, req.wdata[6:0]};
      end else if (req.index == `CRTV_IDX_MODE) begin
        mode_q <= {req.wdata[7:5], 1'b0, req.wdata[3:0]};
      end else if (req.index == `CRTV_IDX_LCMP_LO) begin
        lcmp_q <= req.wdata;
      end else if (req.index == `CRTV_IDX_OVFL) begin
        ovfl_q <= req.wdata;
      end else if (req.index == `CRTV_IDX_MAXSCAN) begin
        msl_q <= req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      if (req.index == `CRTV_IDX_ULOC) begin
        rdata_q <= uloc_q;
      end else if (req.index == `CRTV_IDX_VBS_LO) begin
        rdata_q <= vbs_q;
      end else if (req.index == `CRTV_IDX_VBE) begin
        rdata_q <= vbe_q;
      end else if (req.index == `CRTV_IDX_MODE) begin
        rdata_q <= mode_q;
      end else if (req.index == `CRTV_IDX_LCMP_LO) begin
        rdata_q <= lcmp_q;
      end else if (req.index == `CRTV_IDX_OVFL) begin
        rdata_q <= ovfl_q;
      end else if (req.index == `CRTV_IDX_MAXSCAN) begin
        rdata_q <= msl_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
endmodule : crtv_regfile

// ### design/crtv_vtiming.sv
`timescale 1ns/1ns
`include "crtv_cfg.svh"
module crtv_vtiming #(
  parameter int unsigned VTOTAL = 10'd524,
  parameter int unsigned HTOTAL = 8'd99,
  parameter int unsigned HSYNC_W = 8'd12,
  parameter int unsigned VSYNC_W = 10'd2,
  parameter int unsigned HDISP = 8'd79,
  parameter int unsigned VDISP = 10'd479,
  parameter int unsigned ROW_MAX = 5'd15,
  parameter int unsigned ROW_WORDS = 16'd40
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Indexed data port (index already loaded by software)
  input  wire crtv_pkg::crtv_req_t    req,
  output logic [7:0]                  rdata_q,
  // Display outputs
  output crtv_pkg::crtv_timing_t      timing_q,
  output logic                        underline_q,
  output logic [15:0]                 mem_addr_q
);
  logic [7:0] uloc_q, vbs_q, vbe_q, mode_q, lcmp_q, ovfl_q, msl_q;
  logic [7:0] rd_w;

  // Software writes the index first, then the data port
  crtv_regfile u_regs (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .req     (req),
    .rdata_q (rd_w),
    .uloc_q  (uloc_q),
    .vbs_q   (vbs_q),
    .vbe_q   (vbe_q),
    .mode_q  (mode_q),
    .lcmp_q  (lcmp_q),
    .ovfl_q  (ovfl_q),
    .msl_q   (msl_q)
  );
  assign rdata_q = rd_w;

  logic        ten;
  logic        dword;
  logic [9:0]  vbs_full;
  logic [9:0]  lc_full;
  assign ten   = mode_q[`CRTV_MODE_TEN];
  assign dword = uloc_q[`CRTV_ULOC_DW];
  assign vbs_full = {msl_q[`CRTV_MSL_VBLANK_START_BIT9], ovfl_q[`CRTV_OVFL_VBLANK_START_BIT8],
                     vbs_q};
  assign lc_full  = {msl_q[`CRTV_MSL_LC9], ovfl_q[`CRTV_OVFL_LC8],
                     lcmp_q};

  // Horizontal character counter; one ref_clk is one character clock
  logic [7:0] hcnt_q;
  logic       hend;
  assign hend = (hcnt_q == 8'(HTOTAL));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q <= 8'h00;
    end else if (!ten || hend) begin
      hcnt_q <= 8'h00;
    end else begin
      hcnt_q <= hcnt_q + 8'h01;
    end
  end

  // Vertical clock: once per line, or every other line when halved
  logic hdiv_q;
  logic vstep;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdiv_q <= 1'b0;
    end else if (hend) begin
      hdiv_q <= ~hdiv_q;
    end
  end
  assign vstep = hend && (!mode_q[`CRTV_MODE_HRS] || hdiv_q);

  // Ten bits wide; halving the clock reaches 2048 display lines
  logic [9:0] vcnt_q;
  logic       vend;
  assign vend = (vcnt_q == 10'(VTOTAL));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcnt_q <= 10'h000;
    end else if (!ten) begin
      vcnt_q <= 10'h000;
    end else if (vstep) begin
      vcnt_q <= vend ? 10'h000 : vcnt_q + 10'h001;
    end
  end

  // Row scan counter within a character row
  logic [4:0] row_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_q <= 5'h00;
    end else if (!ten || (vstep && vend)) begin
      row_q <= 5'h00;
    end else if (vstep && (vcnt_q + 10'h001 == lc_full)) begin
      row_q <= 5'h00;
    end else if (vstep) begin
      row_q <= (row_q == 5'(ROW_MAX)) ? 5'h00 : row_q + 5'h01;
    end
  end

  // Blanking flag set at the start compare, cleared at the end compare
  logic vblank_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vblank_q <= 1'b0;
    end else if (!ten) begin
      vblank_q <= 1'b0;
    end else if (vstep) begin
      if (vcnt_q + 10'h001 == vbs_full) begin
        vblank_q <= 1'b1;
      end else if ((vcnt_q[6:0] + 7'h01) == vbe_q[6:0]) begin
        vblank_q <= 1'b0;
      end
    end
  end

  // Refresh address counter with divide by one, two or four
  logic [1:0]  cdiv_q;
  logic        astep;
  logic [15:0] line_base_q;
  logic [15:0] addr_q;
  logic        hact;
  assign hact = (hcnt_q <= 8'(HDISP)) && (vcnt_q <= 10'(VDISP));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cdiv_q <= 2'b00;
    end else if (hend) begin
      cdiv_q <= 2'b00;
    end else begin
      cdiv_q <= cdiv_q + 2'b01;
    end
  end
  always_comb begin
    if (dword && uloc_q[`CRTV_ULOC_CB4]) begin
      astep = (cdiv_q == 2'b11);
    end else if (mode_q[`CRTV_MODE_CBT]) begin
      astep = cdiv_q[0];
    end else begin
      astep = 1'b1;
    end
  end

  // Line base restarts at zero below the split, so scrolling does not apply.
  // The next base feeds the address load, so a new line starts from it at
  // once instead of one line late.
  logic [15:0] line_base_d;
  always_comb begin
    if (!ten || (vstep && vend)) begin
      line_base_d = 16'h0000;
    end else if (vstep && (vcnt_q + 10'h001 == lc_full)) begin
      line_base_d = 16'h0000;
    end else if (vstep && row_q == 5'(ROW_MAX)) begin
      line_base_d = line_base_q + 16'(ROW_WORDS);
    end else begin
      line_base_d = line_base_q;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_base_q <= 16'h0000;
    end else begin
      line_base_q <= line_base_d;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 16'h0000;
    end else if (hend) begin
      addr_q <= line_base_d;
    end else if (hact && astep) begin
      addr_q <= addr_q + 16'h0001;
    end
  end

  // Address formatting and output multiplexer
  logic [15:0] fmt;
  always_comb begin
    if (dword) begin
      fmt = {addr_q[13:0], addr_q[15:14]};
    end else if (!mode_q[`CRTV_MODE_WB]) begin
      // Output bit n carries counter bit n-1; bit 0 takes 13 or 15
      fmt = {addr_q[14:0], mode_q[`CRTV_MODE_AW] ? addr_q[15]
                                                  : addr_q[13]};
    end else begin
      fmt = addr_q;
    end
    fmt[14] = mode_q[`CRTV_MODE_SRS] ? fmt[14] : row_q[1];
    fmt[13] = mode_q[`CRTV_MODE_CMS] ? fmt[13] : row_q[0];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_q <= 16'h0000;
    end else begin
      mem_addr_q <= fmt;
    end
  end

  // Sync, enable and blanking outputs, all forced off while disabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timing_q <= '0;
    end else if (!ten) begin
      timing_q <= '0;
    end else begin
      timing_q.hsync <= (hcnt_q > 8'(HTOTAL - HSYNC_W));
      timing_q.vsync <= (vcnt_q > 10'(VTOTAL - VSYNC_W));
      timing_q.den   <= hact;
      timing_q.blank <= vblank_q || !hact;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      underline_q <= 1'b0;
    end else begin
      underline_q <= ten && hact &&
                     ({1'b0, row_q} == {1'b0, uloc_q[4:0]} + 6'h01);
    end
  end
endmodule : crtv_vtiming

// ### testbench/crtv_vtiming_assertions.sv
`timescale 1ns/1ns
`include "crtv_cfg.svh"
module crtv_vtiming_chk (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  // Register port
  input wire crtv_pkg::crtv_req_t    req,
  input wire logic [7:0]             rdata_q,
  // Display side
  input wire crtv_pkg::crtv_timing_t timing_q,
  input wire logic                   underline_q,
  input wire logic [15:0]            mem_addr_q
);
  logic [7:0] sh_q [5];
  logic       rd_ok;
  logic       unmap;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Write and read on one edge is left unjudged: the read returns the old value
  assign rd_ok = req.rd && !req.wr;
  assign unmap = (req.index < 8'h14 || req.index > 8'h18)
    && req.index != `CRTV_IDX_OVFL && req.index != `CRTV_IDX_MAXSCAN;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= '{default: 8'h00};
    end else if (req.wr && !unmap && req.index >= 8'h14) begin
      sh_q[3'(req.index - 8'h14)] <= req.wdata;
    end
  end
  property p_uloc_rd;
    rd_ok && req.index == `CRTV_IDX_ULOC |=> rdata_q == (sh_q[0] & 8'h7f);
  endproperty
  a_uloc_rd: assert property (p_uloc_rd) else $error("uloc read");
  property p_vbs_rd;
    rd_ok && req.index == `CRTV_IDX_VBS_LO |=> rdata_q == sh_q[1];
  endproperty
  a_vbs_rd: assert property (p_vbs_rd) else $error("vbs read");
  property p_vbe_rd;
    rd_ok && req.index == `CRTV_IDX_VBE |=> rdata_q == (sh_q[2] & 8'h7f);
  endproperty
  a_vbe_rd: assert property (p_vbe_rd) else $error("vbe read");
  property p_mode_rd;
    rd_ok && req.index == `CRTV_IDX_MODE |=> rdata_q == (sh_q[3] & 8'hef);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read");
  property p_lcmp_rd;
    rd_ok && req.index == `CRTV_IDX_LCMP_LO |=> rdata_q == sh_q[4];
  endproperty
  a_lcmp_rd: assert property (p_lcmp_rd) else $error("lcmp read");
  property p_unmap_rd;
    rd_ok && unmap |=> rdata_q == 8'h00;
  endproperty
  a_unmap_rd: assert property (p_unmap_rd) else $error("unmap read");
  property p_rd_hold;
    !$past(req.rd) |-> $stable(rdata_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_timing_off;
    !sh_q[3][7] && !$past(sh_q[3][7]) |-> timing_q == '0;
  endproperty
  a_timing_off: assert property (p_timing_off) else $error("timing on");
  c_ul: cover property (underline_q);
  c_vs: cover property (timing_q.vsync);
  c_bl: cover property (timing_q.blank && mem_addr_q != 16'h0000);
endmodule : crtv_vtiming_chk

bind crtv_vtiming crtv_vtiming_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata_q(rdata_q),
  .timing_q(timing_q), .underline_q(underline_q), .mem_addr_q(mem_addr_q));

// ### testbench/crtv_crt_mon.sv
`timescale 1ns/1ns
// Monitor end only: refresh data is not modelled, just frame timing
module crtv_crt_mon (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Display side
  input  wire crtv_pkg::crtv_timing_t tm,
  output int                          frames,
  output int                          per
);
  int   cyc;
  int   last;
  logic prev;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc    <= 0;
      last   <= 0;
      prev   <= 1'b0;
      frames <= 0;
      per    <= 0;
    end else begin
      cyc  <= cyc + 1;
      prev <= tm.vsync;
      if (tm.vsync && !prev) begin
        frames <= frames + 1;
        per    <= cyc - last;
        last   <= cyc;
      end
    end
  end
endmodule : crtv_crt_mon

// ### testbench/tb.sv
`timescale 1ns/1ns
`include "crtv_cfg.svh"
module tb;
  logic                   ref_clk;
  logic                   rst_n;
  crtv_pkg::crtv_req_t    req;
  logic [7:0]             rdata_q;
  crtv_pkg::crtv_timing_t timing_q;
  logic                   underline_q;
  logic [15:0]            mem_addr_q;
  int                     frames;
  int                     per;
  int                     n_errors;
  int                     tests_run;
  int                     cyc;
  logic                   seen_ul;
  logic                   seen_bl;

  crtv_vtiming #(.VTOTAL(20), .HTOTAL(9), .HDISP(5), .VDISP(10)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata_q(rdata_q),
    .timing_q(timing_q), .underline_q(underline_q),
    .mem_addr_q(mem_addr_q));
  crtv_crt_mon mon (.ref_clk(ref_clk), .rst_n(rst_n), .tm(timing_q),
    .frames(frames), .per(per));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cyc++;
    if (underline_q === 1'b1) seen_ul = 1'b1;
    // Blank inside the active area can only come from the vertical blank
    if (timing_q.blank === 1'b1 && timing_q.den === 1'b1) seen_bl = 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One access held across one taken edge
  task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    req = '{wr: w, rd: !w, index: i, wdata: d};
    @(posedge ref_clk);
    #2;
    req = '0;
  endtask : acc

  task automatic wait_fr(input int n);
    int f;
    f = frames;
    for (int i = 0; i < 4000 && frames < f + n; i++) @(posedge ref_clk);
    chk("frames", 16'h1, {15'h0, frames >= f + n});
  endtask : wait_fr

  task automatic t_regs();
    logic [7:0] ix [5] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    logic [7:0] mk [5] = '{8'h7f, 8'hff, 8'h7f, 8'hef, 8'hff};
    acc(1'b0, `CRTV_IDX_MODE, 8'h00);
    chk("mode reset", 16'h0, {8'h0, rdata_q});
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, ix[i], 8'hff);
      acc(1'b0, ix[i], 8'h00);
      chk("readback", {8'h0, mk[i]}, {8'h0, rdata_q});
    end
    acc(1'b1, 8'h20, 8'h5a);
    acc(1'b0, 8'h20, 8'h00);
    chk("unmapped", 16'h0, {8'h0, rdata_q});
    $display("t_regs done");
  endtask : t_regs

  task automatic t_period();
    int p0;
    acc(1'b1, `CRTV_IDX_VBS_LO, 8'd8);
    acc(1'b1, `CRTV_IDX_VBE, 8'd18);
    acc(1'b1, `CRTV_IDX_ULOC, 8'h00);
    acc(1'b1, `CRTV_IDX_MODE, 8'h80);
    seen_ul = 1'b0;
    seen_bl = 1'b0;
    wait_fr(3);
    p0 = per;
    chk("frame period", 16'd210, 16'(p0));
    chk("underline", 16'h1, {15'h0, seen_ul});
    chk("vblank", 16'h1, {15'h0, seen_bl});
    // Halved vertical clock must double the frame
    acc(1'b1, `CRTV_IDX_MODE, 8'h84);
    wait_fr(3);
    chk("halved vclk", 16'(2 * p0), 16'(per));
    $display("t_period done");
  endtask : t_period

  // Refresh address on the first line of a frame: first and third cycle
  task automatic t_addr(input logic [7:0] md, input logic [15:0] e);
    int n;
    acc(1'b1, `CRTV_IDX_MODE, md);
    n = 0;
    while (timing_q.vsync !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    while (timing_q.den !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    chk("addr first", 16'h0000, mem_addr_q);
    repeat (2) begin
      @(posedge ref_clk);
      #2;
    end
    chk("addr third", e, mem_addr_q);
    $display("t_addr done");
  endtask : t_addr

  task automatic t_off();
    int f;
    acc(1'b1, `CRTV_IDX_MODE, 8'h00);
    repeat (2) @(posedge ref_clk);
    f = frames;
    repeat (300) begin
      @(posedge ref_clk);
      #2;
      chk("timing off", 16'h0, {12'h0, timing_q});
    end
    chk("no frames", 16'(f), 16'(frames));
    $display("t_off done");
  endtask : t_off

  initial begin
    rst_n = 1'b0;
    req = '0;
    seen_ul = 1'b0;
    seen_bl = 1'b0;
    repeat (4) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    t_regs();
    t_period();
    t_addr(8'hc3, 16'h0002);
    t_addr(8'hcb, 16'h0001);
    t_addr(8'h83, 16'h0004);
    t_off();
    test_done();
  end
endmodule : tb
